// >>> cqt_top.sv
// Counter/timer channel, three quadrature decoders and their AXI4-Lite register file
`timescale 1ns/1ns
`include "cqt_defines.svh"
module cqt_top
	import cqt_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ct_gate_pin,
	input  wire logic        ct_clk_pin,
	input  wire logic [2:0]  qd_a_pin,
	input  wire logic [2:0]  qd_b_pin,
	input  wire logic [2:0]  qd_idx_pin,
	output logic             ct_out
);
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        wr_go;
	logic [31:0] ctrl_reg;
	logic [31:0] div_reg;
	logic [31:0] period_reg;
	logic [31:0] active_reg;
	logic [31:0] qd_cfg_reg [`CQT_QD_NUM];
	logic [31:0] qd_pos [`CQT_QD_NUM];
	logic        cmd_start_reg;
	logic        cmd_stop_reg;
	cqt_state_t  state_reg;
	cqt_state_t  state_next;
	logic [31:0] count_reg;
	logic [31:0] div_cnt_reg;
	logic [23:0] dda_reg;
	logic [31:0] phase_reg;
	logic        out_reg;
	logic [1:0]  pin_lvl;
	logic [1:0]  pin_rise;
	logic [1:0]  pin_fall;
	logic [3:0]  events;
	cqt_mode_t   mode;
	logic        pol_high;
	logic        gate_high;
	logic        ext_src;
	logic        gate_none;
	logic        tick;
	logic        gate_ok;
	logic        trig;
	logic        start_ev;
	logic        stop_ev;
	logic [31:0] period_eff;
	logic        last_tick;
	logic        active_now;
	logic        dda_carry;

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// True for any mapped register address
	function automatic logic addr_known(input logic [7:0] a);
		logic ok;
		ok = (a <= `CQT_CT_STATUS) && (a[1:0] == 2'b00);
		for (int i = 0; i < `CQT_QD_NUM; i++) begin
			if (a == `CQT_QD_CFG0 + 8'(i) * `CQT_QD_STRIDE || a == `CQT_QD_POS0 + 8'(i) * `CQT_QD_STRIDE) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction

	// Write address and data are taken independently, then answered together
	assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `CQT_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				wready_reg <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= addr_known(aw_addr_reg) ? `CQT_RESP_OKAY : `CQT_RESP_DECERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Software-written configuration registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_reg   <= `CQT_RST_CTRL;
			div_reg    <= `CQT_RST_DIV;
			period_reg <= `CQT_RST_PERIOD;
			active_reg <= `CQT_RST_ACTIVE;
			for (int i = 0; i < `CQT_QD_NUM; i++) begin
				qd_cfg_reg[i] <= `CQT_RST_QDCFG;
			end
		end else if (wr_go) begin
			unique case (aw_addr_reg)
				`CQT_CT_CTRL:   ctrl_reg <= apply_strb(ctrl_reg, w_data_reg, w_strb_reg);
				`CQT_CT_DIV:    div_reg <= apply_strb(div_reg, w_data_reg, w_strb_reg);
				`CQT_CT_PERIOD: period_reg <= apply_strb(period_reg, w_data_reg, w_strb_reg);
				`CQT_CT_ACTIVE: active_reg <= apply_strb(active_reg, w_data_reg, w_strb_reg);
				default: begin
					for (int i = 0; i < `CQT_QD_NUM; i++) begin
						if (aw_addr_reg == `CQT_QD_CFG0 + 8'(i) * `CQT_QD_STRIDE) begin
							qd_cfg_reg[i] <= apply_strb(qd_cfg_reg[i], w_data_reg, w_strb_reg);
						end
					end
				end
			endcase
		end
	end

	// Command register gives one-cycle start and stop pulses
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cmd_start_reg <= 1'b0;
			cmd_stop_reg  <= 1'b0;
		end else begin
			cmd_start_reg <= wr_go && aw_addr_reg == `CQT_CT_CMD && w_strb_reg[0] && w_data_reg[`CQT_CMD_START];
			cmd_stop_reg  <= wr_go && aw_addr_reg == `CQT_CT_CMD && w_strb_reg[0] && w_data_reg[`CQT_CMD_STOP];
		end
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `CQT_RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rresp_reg   <= addr_known(s_axi_araddr) ? `CQT_RESP_OKAY : `CQT_RESP_DECERR;
			rdata_reg   <= 32'h0000_0000;
			unique case (s_axi_araddr)
				`CQT_CT_CTRL:   rdata_reg <= ctrl_reg;
				`CQT_CT_DIV:    rdata_reg <= div_reg;
				`CQT_CT_PERIOD: rdata_reg <= period_reg;
				`CQT_CT_ACTIVE: rdata_reg <= active_reg;
				`CQT_CT_COUNT:  rdata_reg <= count_reg;
				`CQT_CT_STATUS: rdata_reg <= {27'h0, out_reg, state_reg};
				default: begin
					for (int i = 0; i < `CQT_QD_NUM; i++) begin
						if (s_axi_araddr == `CQT_QD_CFG0 + 8'(i) * `CQT_QD_STRIDE) begin
							rdata_reg <= qd_cfg_reg[i];
						end
						if (s_axi_araddr == `CQT_QD_POS0 + 8'(i) * `CQT_QD_STRIDE) begin
							rdata_reg <= qd_pos[i];
						end
					end
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Gate and external clock pins, synchronised before edge detection
	cqt_sync #(.W(2)) u_ct_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({ct_clk_pin, ct_gate_pin}),
		.lvl      (pin_lvl),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	// Configuration fields and selectable edge events
	assign mode      = cqt_mode_t'(ctrl_reg[`CQT_CTRL_MODE +: 3]);
	assign pol_high  = ctrl_reg[`CQT_CTRL_POL];
	assign gate_high = ctrl_reg[`CQT_CTRL_GLVL];
	assign ext_src   = ctrl_reg[`CQT_CTRL_CSRC];
	assign gate_none = ctrl_reg[`CQT_CTRL_GNONE];
	assign events    = {pin_fall[1], pin_rise[1], pin_fall[0], pin_rise[0]};
	assign start_ev  = events[ctrl_reg[`CQT_CTRL_START +: 2]];
	assign stop_ev   = events[ctrl_reg[`CQT_CTRL_STOP +: 2]];
	assign gate_ok   = gate_none || (gate_high ? pin_lvl[0] : !pin_lvl[0]);
	assign trig      = gate_none || (gate_high ? pin_rise[0] : pin_fall[0]);
	assign tick      = ext_src ? pin_rise[1] : (div_cnt_reg >= div_reg);

	// Internal clock divider producing the count tick
	always_ff @(posedge core_clk) begin
		if (!nrst || cmd_start_reg || div_cnt_reg >= div_reg) begin
			div_cnt_reg <= 32'h0000_0000;
		end else begin
			div_cnt_reg <= div_cnt_reg + 32'h1;
		end
	end

	// Mode sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CQT_ST_IDLE: state_next = CQT_ST_IDLE;
			CQT_ST_ARMED: begin
				if (mode == CQT_MODE_MEASURE && start_ev) begin
					state_next = CQT_ST_RUN;
				end else if (mode == CQT_MODE_RATE && gate_ok) begin
					state_next = CQT_ST_RUN;
				end else if ((mode == CQT_MODE_ONESHOT || mode == CQT_MODE_REPEAT) && trig) begin
					state_next = CQT_ST_RUN;
				end
			end
			CQT_ST_RUN: begin
				if (mode == CQT_MODE_MEASURE && stop_ev) begin
					state_next = CQT_ST_DONE;
				end else if (mode == CQT_MODE_RATE && !gate_ok) begin
					state_next = CQT_ST_ARMED;
				end else if (mode == CQT_MODE_ONESHOT && tick && last_tick) begin
					state_next = CQT_ST_DONE;
				end else if (mode == CQT_MODE_REPEAT && tick && last_tick) begin
					state_next = CQT_ST_ARMED;
				end
			end
			CQT_ST_DONE: state_next = CQT_ST_DONE;
		endcase
		if (cmd_start_reg) begin
			state_next = (mode == CQT_MODE_IDLE) ? CQT_ST_IDLE : CQT_ST_ARMED;
		end
		if (cmd_stop_reg) begin
			state_next = CQT_ST_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= CQT_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Fractional accumulator so that the count averages 18 MHz on this clock
	assign dda_carry = (dda_reg + 24'(`CQT_DDA_FRAC)) >= 24'(`CQT_CLK_HZ);
	always_ff @(posedge core_clk) begin
		if (!nrst || cmd_start_reg) begin
			dda_reg <= 24'h000000;
		end else if (state_reg == CQT_ST_RUN && mode == CQT_MODE_MEASURE) begin
			dda_reg <= dda_carry ? dda_reg + 24'(`CQT_DDA_FRAC) - 24'(`CQT_CLK_HZ)
				: dda_reg + 24'(`CQT_DDA_FRAC);
		end
	end

	// Interval counter: runs between start and stop, then holds; wraps at 32 bits
	always_ff @(posedge core_clk) begin
		if (!nrst || cmd_start_reg) begin
			count_reg <= 32'h0000_0000;
		end else if (state_reg == CQT_ST_RUN && mode == CQT_MODE_MEASURE && !stop_ev && !cmd_stop_reg) begin
			count_reg <= count_reg + 32'(`CQT_DDA_WHOLE) + {31'h0, dda_carry};
		end
	end

	// Output period phase, counted in ticks of the selected count clock
	assign period_eff = (period_reg == 32'h0) ? 32'h1 : period_reg;
	assign last_tick  = phase_reg >= period_eff - 32'h1;
	assign active_now = (period_eff - phase_reg) <= active_reg;
	always_ff @(posedge core_clk) begin
		if (!nrst || state_reg != CQT_ST_RUN || cmd_start_reg) begin
			phase_reg <= 32'h0000_0000;
		end else if (tick) begin
			phase_reg <= last_tick ? 32'h0000_0000 : phase_reg + 32'h1;
		end
	end

	// Pulse output: active level while in the active part of a period
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			out_reg <= 1'b0;
		end else if (state_reg == CQT_ST_RUN && mode != CQT_MODE_MEASURE && active_now && !cmd_stop_reg
			&& !cmd_start_reg && !(mode == CQT_MODE_RATE && !gate_ok)) begin
			out_reg <= pol_high;
		end else begin
			out_reg <= !pol_high;
		end
	end

	assign ct_out = out_reg;

	// Three concurrent quadrature decoders
	cqt_qd_if qd_bus [`CQT_QD_NUM] ();
	for (genvar g = 0; g < `CQT_QD_NUM; g++) begin : g_qd
		assign qd_bus[g].prescale         = qd_cfg_reg[g][15:0];
		assign qd_bus[g].four_edge_decode = qd_cfg_reg[g][`CQT_QD_FOUR];
		assign qd_bus[g].index_en         = qd_cfg_reg[g][`CQT_QD_INDEX];
		assign qd_pos[g]                  = qd_bus[g].pos;
		cqt_qdec u_qdec (
			.core_clk (core_clk),
			.nrst     (nrst),
			.enc_a    (qd_a_pin[g]),
			.enc_b    (qd_b_pin[g]),
			.enc_idx  (qd_idx_pin[g]),
			.bus      (qd_bus[g].dec)
		);
	end
endmodule

// >>> cqt_defines.svh
// Register offsets, field positions, reset values and timing counts of the counter/timer block
`ifndef CQT_DEFINES_SVH
`define CQT_DEFINES_SVH
`define CQT_CLK_HZ       10000000
`define CQT_CNT_HZ       18000000
`define CQT_DDA_WHOLE    (`CQT_CNT_HZ / `CQT_CLK_HZ)
`define CQT_DDA_FRAC     (`CQT_CNT_HZ % `CQT_CLK_HZ)
`define CQT_ADDR_W       8
`define CQT_CT_CTRL      8'h00
`define CQT_CT_CMD       8'h04
`define CQT_CT_DIV       8'h08
`define CQT_CT_PERIOD    8'h0c
`define CQT_CT_ACTIVE    8'h10
`define CQT_CT_COUNT     8'h14
`define CQT_CT_STATUS    8'h18
`define CQT_QD_CFG0      8'h20
`define CQT_QD_POS0      8'h24
`define CQT_QD_STRIDE    8'h08
`define CQT_QD_NUM       3
`define CQT_CTRL_MODE    0
`define CQT_CTRL_POL     3
`define CQT_CTRL_GLVL    4
`define CQT_CTRL_CSRC    5
`define CQT_CTRL_START   6
`define CQT_CTRL_STOP    8
`define CQT_CTRL_GNONE   10
`define CQT_CMD_START    0
`define CQT_CMD_STOP     1
`define CQT_QD_FOUR      16
`define CQT_QD_INDEX     17
`define CQT_RST_CTRL     32'h0000_0000
`define CQT_RST_DIV      32'h0000_0000
`define CQT_RST_PERIOD   32'h0000_0002
`define CQT_RST_ACTIVE   32'h0000_0001
`define CQT_RST_QDCFG    32'h0000_0000
`define CQT_RESP_OKAY    2'h0
`define CQT_RESP_DECERR  2'h3
`endif

// >>> cqt_pkg.sv
// Types shared by the counter/timer and quadrature decoder modules
package cqt_pkg;
	typedef enum logic [2:0] {
		CQT_MODE_IDLE    = 3'h0,
		CQT_MODE_MEASURE = 3'h1,
		CQT_MODE_RATE    = 3'h2,
		CQT_MODE_ONESHOT = 3'h3,
		CQT_MODE_REPEAT  = 3'h4
	} cqt_mode_t;
	typedef enum logic [1:0] {
		CQT_EV_GATE_RISE = 2'h0,
		CQT_EV_GATE_FALL = 2'h1,
		CQT_EV_CLK_RISE  = 2'h2,
		CQT_EV_CLK_FALL  = 2'h3
	} cqt_edge_t;
	typedef enum logic [3:0] {
		CQT_ST_IDLE  = 4'h1,
		CQT_ST_ARMED = 4'h2,
		CQT_ST_RUN   = 4'h4,
		CQT_ST_DONE  = 4'h8
	} cqt_state_t;
endpackage

// >>> cqt_qd_if.sv
// Configuration and position carrier between the register file and one decoder
`timescale 1ns/1ns
interface cqt_qd_if;
	logic [15:0] prescale;
	logic        four_edge_decode;
	logic        index_en;
	logic [31:0] pos;
	modport dec (input prescale, input four_edge_decode, input index_en, output pos);
	modport host (output prescale, output four_edge_decode, output index_en, input pos);
endinterface

// >>> cqt_sync.sv
// Two-stage synchroniser with edge detection on the synchronised level
`timescale 1ns/1ns
module cqt_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	// Meta stage feeds only the sync stage; edges compare sync and prev
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign lvl  = sync_reg;
	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;
endmodule

// >>> cqt_qdec.sv
// One quadrature decoder channel with prescaled noise filter and index zeroing
`timescale 1ns/1ns
module cqt_qdec
	import cqt_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic enc_a,
	input  wire logic enc_b,
	input  wire logic enc_idx,
	cqt_qd_if.dec     bus
);
	logic [2:0]  in_s;
	logic [15:0] pre_cnt_reg;
	logic [2:0]  h0_reg;
	logic [2:0]  h1_reg;
	logic [2:0]  filt_reg;
	logic [2:0]  prev_reg;
	logic [31:0] pos_reg;
	logic [2:0]  agree;
	logic [1:0]  step;

	// Returns {count, up} for a move between two filtered A/B states
	function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c, input logic four);
		logic [1:0] r;
		r = 2'b00;
		if (four) begin
			unique case ({p, c})
				4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'b11;
				4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'b10;
				default: r = 2'b00;
			endcase
		end else if (p == 2'b00 && c == 2'b01) begin
			r = 2'b11;
		end else if (p == 2'b01 && c == 2'b00) begin
			r = 2'b10;
		end
		return r;
	endfunction

	cqt_sync #(.W(3)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({enc_idx, enc_b, enc_a}),
		.lvl      (in_s),
		.rise     (),
		.fall     ()
	);

	// Accept a level only after three equal prescaled samples
	assign agree = ~(h0_reg ^ h1_reg) & ~(h1_reg ^ in_s);
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pre_cnt_reg <= 16'h0000;
			h0_reg      <= 3'h0;
			h1_reg      <= 3'h0;
			filt_reg    <= 3'h0;
		end else if (pre_cnt_reg >= bus.prescale) begin
			pre_cnt_reg <= 16'h0000;
			h0_reg      <= in_s;
			h1_reg      <= h0_reg;
			filt_reg    <= (filt_reg & ~agree) | (in_s & agree);
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 16'h0001;
		end
	end

	assign step = quad_step(prev_reg[1:0], filt_reg[1:0], bus.four_edge_decode);

	// Position count: index zeroing wins over a step
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prev_reg <= 3'h0;
			pos_reg  <= 32'h0000_0000;
		end else begin
			prev_reg <= filt_reg;
			if (bus.index_en && filt_reg[2] && !prev_reg[2]) begin
				pos_reg <= 32'h0000_0000;
			end else if (step[1]) begin
				pos_reg <= step[0] ? pos_reg + 32'h1 : pos_reg - 32'h1;
			end
		end
	end

	assign bus.pos = pos_reg;
endmodule

// >>> cqt_checker.sv
// Register bus handshake checks for the counter/timer block
`timescale 1ns/1ns
module cqt_checker (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Requests taken on the read and write sides
	sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	chk_rd_answer:
	assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
	chk_rd_unmapped:
	assert property (s_rd_take ##0 (s_axi_araddr == 8'h1c) |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
		else $error("unmapped read wrong");
	chk_rd_release:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read stuck");
	chk_rd_busy:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	chk_wr_answer:
	assert property (s_wr_take |=> (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) ##1 s_axi_bvalid)
		else $error("write not answered");
	chk_wr_release:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write stuck");
	chk_wr_busy:
	assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	chk_reset_idle:
	assert property (@(posedge core_clk) disable iff (1'b0) !nrst |=> s_axi_arready && !s_axi_rvalid && !s_axi_bvalid)
		else $error("bus not idle after reset");
endmodule
bind cqt_top cqt_checker u_chk (.*);

// >>> cqt_enc_model.sv
// Three quadrature encoders with index marks, stepped on request
`timescale 1ns/1ns
module cqt_enc_model (
	input  wire logic       core_clk,
	output logic      [2:0] enc_a,
	output logic      [2:0] enc_b,
	output logic      [2:0] enc_idx
);
	logic [1:0] ph [3] = '{2'h0, 2'h0, 2'h0};
	// Lines start low
	initial begin
		enc_a = 3'h0;
		enc_b = 3'h0;
		enc_idx = 3'h0;
	end
	// Gray quarter steps; going up, A moves a quarter ahead of B
	task automatic move(input int ch, input bit up, input int n, input int hold);
		repeat (4 * n) begin
			ph[ch] = up ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
			enc_a[ch] <= ^ph[ch];
			enc_b[ch] <= ph[ch][1];
			repeat (hold) @(posedge core_clk);
		end
	endtask
	// Index mark on the masked channels for len cycles
	task automatic mark(input logic [2:0] m, input int len);
		enc_idx <= m;
		repeat (len) @(posedge core_clk);
		enc_idx <= 3'h0;
	endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the counter/timer and quadrature decoders
`timescale 1ns/1ns
module tb_top;
	logic        core_clk, nrst, ct_gate_pin, ct_clk_pin, ct_out;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot, qd_a_pin, qd_b_pin, qd_idx_pin;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, c;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          fails, checked, hi, f, f0, f1;
	// Reset image rows: address, word, response
	logic [41:0] rows [10] = '{{8'h00, 32'h0, 2'h0}, {8'h08, 32'h0, 2'h0}, {8'h0c, 32'h2, 2'h0},
		{8'h10, 32'h1, 2'h0}, {8'h14, 32'h0, 2'h0}, {8'h18, 32'h11, 2'h0}, {8'h20, 32'h0, 2'h0},
		{8'h24, 32'h0, 2'h0}, {8'h34, 32'h0, 2'h0}, {8'h1c, 32'h0, 2'h3}};
	// Rate rows: divider, period, active, polarity and gate level, highs in 40 cycles
	int          rt [3][5] = '{'{0, 4, 1, 1, 10}, '{0, 4, 1, 0, 30}, '{1, 5, 2, 1, 16}};
	cqt_top DUT (.*);
	cqt_enc_model u_enc (.core_clk(core_clk), .enc_a(qd_a_pin), .enc_b(qd_b_pin), .enc_idx(qd_idx_pin));
	// 100 ns clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic guard(input int n);
		if (n >= 100) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Write with address and data offered together, response compared
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		s_axi_bready <= 1'b0;
		guard(n);
		chk("bresp", s_axi_bresp, er);
	endtask
	// Read one word and compare data and response
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		guard(n);
		chk(nm, d, e);
		chk("rresp", r, er);
	endtask
	// Count high output cycles over n edges, first one noted
	task automatic watch(input int n);
		hi = 0;
		f = -1;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			if (ct_out === 1'b1 && f < 0)
				f = i;
			if (ct_out === 1'b1)
				hi++;
		end
	endtask
	// Main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ct_gate_pin, ct_clk_pin} = '0;
		s_axi_wstrb = 4'hf;
		nrst = 1'b0;
		tick(20);
		nrst <= 1'b1;
		wr(8'h14, 32'h55);
		wr(8'h1c, 32'h55, 2'h3);
		for (int i = 0; i < 10; i++)
			rdc("reset image", rows[i][41:34], rows[i][33:2], rows[i][1:0]);
		// Three decoders together, then down, index and filtering
		wr(8'h20, 32'h1_0000);
		wr(8'h30, 32'h3_0000);
		fork
			u_enc.move(0, 1, 3, 8);
			u_enc.move(1, 1, 3, 8);
			u_enc.move(2, 1, 3, 8);
		join
		tick(10);
		rdc("pos0", 8'h24, 32'd12);
		rdc("pos1", 8'h2c, 32'd3);
		rdc("pos2", 8'h34, 32'd12);
		u_enc.move(0, 0, 1, 8);
		u_enc.mark(3'h5, 8);
		tick(10);
		rdc("pos0 down", 8'h24, 32'd8);
		rdc("pos2 index", 8'h34, 32'd0);
		wr(8'h30, 32'h3_0003);
		u_enc.move(2, 1, 1, 20);
		u_enc.mark(3'h4, 2);
		tick(30);
		rdc("pos2 filter", 8'h34, 32'd4);
		// Interval over every start edge, stop on the opposite edge of the same pin
		for (int k = 0; k < 4; k++) begin
			if (k < 2)
				ct_gate_pin <= k[0];
			else
				ct_clk_pin <= k[0];
			wr(8'h00, 32'h1 | (k << 6) | ((k ^ 1) << 8));
			wr(8'h04, 32'h1);
			for (int t = 0; t < 4; t++) begin
				tick(t == 1 ? 50 : 10);
				if (t == 0)
					rdc("count", 8'h14, 32'd0);
				if (k < 2)
					ct_gate_pin <= k[0] ^ !t[0];
				else
					ct_clk_pin <= k[0] ^ !t[0];
			end
			tick(10);
			rdc("status", 8'h18, 32'h18, 2'h0);
			c = d;
			chk("interval", c[3:0] == 4'h8 ? 1 : 0, 1);
			rdc("held", 8'h14, 32'd88);
			chk("interval span", d >= 87 && d <= 92, 1);
		end
		// Rate generation rows
		for (int k = 0; k < 3; k++) begin
			ct_gate_pin <= !rt[k][3];
			wr(8'h08, rt[k][0]);
			wr(8'h0c, rt[k][1]);
			wr(8'h10, rt[k][2]);
			wr(8'h00, 32'h2 | (rt[k][3] << 3) | (rt[k][3] << 4));
			wr(8'h04, 32'h1);
			ct_gate_pin <= rt[k][3];
			tick(10);
			watch(40);
			chk("rate highs", hi, rt[k][4]);
			ct_gate_pin <= !rt[k][3];
			tick(4);
			watch(20);
			chk("rate stopped", hi, rt[k][3] ? 0 : 20);
		end
		// One-shot at full and short active part
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'd10);
		for (int k = 0; k < 2; k++) begin
			wr(8'h10, k ? 32'd3 : 32'd10);
			wr(8'h00, 32'h1b);
			wr(8'h04, 32'h1);
			ct_gate_pin <= 1'b1;
			watch(30);
			chk("one-shot width", hi, k ? 3 : 10);
			if (k)
				f1 = f;
			else
				f0 = f;
			ct_gate_pin <= 1'b0;
			tick(4);
			ct_gate_pin <= 1'b1;
			watch(30);
			chk("one-shot rearm", hi, 0);
			ct_gate_pin <= 1'b0;
		end
		chk("one-shot delay", f1 - f0, 7);
		// Repetitive one-shot with an edge in the delay before the pulse, then stopped
		wr(8'h00, 32'h1c);
		wr(8'h04, 32'h1);
		fork
			watch(80);
			for (int t = 0; t < 5; t++) begin
				ct_gate_pin <= !t[0];
				tick(t == 3 ? 30 : 3);
			end
		join
		chk("repeat highs", hi, 6);
		wr(8'h04, 32'h2);
		ct_gate_pin <= 1'b0;
		tick(4);
		ct_gate_pin <= 1'b1;
		watch(30);
		chk("repeat stopped", hi, 0);
		wrap_up();
	end
endmodule
